// ### rtl/ssup_top.sv
// switchgear position supervisor: element and truck instances
`timescale 1ns/1ps
`include "ssup_defines.svh"

// Contract
// - position code 0 indet 1 open 2 closed 3 disturbed
// - withdrawn forces element position to open
// - plug removed sets supervision state withdrawn
// - position feedback ignored while withdrawn
// - element and truck are independent instances
// - element operable withdrawn or inserted
// - element has four inputs, truck two
// - protection commands optionally share command relays
// - separate close and open travel times each
// - command held at most travel time, ends early
// - feedback sampled continuously against travel timers
// - close: indet while timing, closed or disturbed
// - open: indet while timing, open or disturbed
// - single contact: reduced one-direction supervision only
// - required contact unassigned reports disturbed
module ssup_top #(
  parameter int TICK_CYCLES = `SSUP_TICK_NS / `SSUP_CLK_NS
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic el_closed_in,
  input wire logic el_open_in,
  input wire logic el_ready_in,
  input wire logic el_withdrawn_in,
  input wire logic tr_closed_in,
  input wire logic tr_open_in,
  input wire logic prot_close,
  input wire logic prot_open,
  output logic el_close_cmd,
  output logic el_open_cmd,
  output logic tr_close_cmd,
  output logic tr_open_cmd,
  output logic [1:0] el_pos,
  output logic [1:0] tr_pos,
  output logic el_withdrawn,
  output logic irq
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_int_b;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_int_b = rst_sync_reg[1];

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  // feedback shows the wanted end position
  function automatic logic reached(input logic c, input logic o,
      input logic won, input logic woff, input logic want_cls);
    logic hit;
    hit = 1'b0;
    if (won && woff) begin
      hit = want_cls ? (c && !o) : (o && !c);
    end else if (won) begin
      hit = want_cls ? c : !c;
    end else if (woff) begin
      hit = want_cls ? !o : o;
    end
    return hit;
  endfunction

  // position from contacts alone, no supervised travel timing
  function automatic logic [1:0] contact_pos(input logic c,
      input logic o, input logic won, input logic woff);
    logic [1:0] p;
    p = `SSUP_POS_DIST;
    if (won && woff) begin
      if (c && !o) begin
        p = `SSUP_POS_CLOSED;
      end else if (o && !c) begin
        p = `SSUP_POS_OPEN;
      end else begin
        p = `SSUP_POS_DIST;
      end
    end else if (won) begin
      p = c ? `SSUP_POS_CLOSED : `SSUP_POS_OPEN;
    end else if (woff) begin
      p = o ? `SSUP_POS_OPEN : `SSUP_POS_CLOSED;
    end
    return p;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ssup_pkg::ssup_state_t state_reg;
  ssup_pkg::ssup_state_t state_next;
  logic [1:0] pin_c;
  logic [1:0] pin_o;
  logic [1:0] cmd_cls;
  logic [1:0] cmd_opn;
  logic wr_cmd;

  assign pin_c = {tr_closed_in, el_closed_in};
  assign pin_o = {tr_open_in, el_open_in};
  assign wr_cmd = reg_wr && (reg_addr == `SSUP_OFS_CMD);
  assign cmd_cls[0] = (wr_cmd && reg_wdata[0]) ||
    (state_reg.ctrl[`SSUP_CTRL_ROUTE] && prot_close);
  assign cmd_opn[0] = (wr_cmd && reg_wdata[1]) ||
    (state_reg.ctrl[`SSUP_CTRL_ROUTE] && prot_open);
  assign cmd_cls[1] = wr_cmd && reg_wdata[2];
  assign cmd_opn[1] = wr_cmd && reg_wdata[3];

  always_comb begin
    logic tk;
    logic won;
    logic woff;
    logic wd;
    logic sup_cls;
    logic sup_opn;
    logic sup;
    logic want_cls;
    logic [3:0] ev;
    logic [15:0] t_load;
    tk = 1'b0;
    won = 1'b0;
    woff = 1'b0;
    wd = 1'b0;
    sup_cls = 1'b0;
    sup_opn = 1'b0;
    sup = 1'b0;
    want_cls = 1'b0;
    ev = 4'h0;
    t_load = 16'h0000;
    state_next = state_reg;
    state_next.rd_data = 32'h0000_0000;

    // plug and ready inputs, three-stage sync
    state_next.sync_wd = {state_reg.sync_wd[1:0], el_withdrawn_in};
    if (state_reg.sync_wd[1] == state_reg.sync_wd[2]) begin
      state_next.wd = state_reg.sync_wd[2];
    end
    state_next.sync_rdy = {state_reg.sync_rdy[1:0], el_ready_in};
    if (state_reg.sync_rdy[1] == state_reg.sync_rdy[2]) begin
      state_next.rdy = state_reg.sync_rdy[2];
    end

    // travel time base
    if (state_reg.tick == 16'(TICK_CYCLES - 1)) begin
      state_next.tick = 16'h0000;
      tk = 1'b1;
    end else begin
      state_next.tick = state_reg.tick + 16'h0001;
    end

    for (int i = 0; i < 2; i++) begin
      won = state_reg.ctrl[2 * i];
      woff = state_reg.ctrl[2 * i + 1];
      wd = (i == 0) && state_reg.wd;
      sup_cls = won;
      sup_opn = woff;

      // contact sync, counted once stages two and three agree
      state_next.inst[i].sync_c = {state_reg.inst[i].sync_c[1:0],
        pin_c[i]};
      state_next.inst[i].sync_o = {state_reg.inst[i].sync_o[1:0],
        pin_o[i]};
      if (state_reg.inst[i].sync_c[1] == state_reg.inst[i].sync_c[2])
      begin
        state_next.inst[i].c = state_reg.inst[i].sync_c[2];
      end
      if (state_reg.inst[i].sync_o[1] == state_reg.inst[i].sync_o[2])
      begin
        state_next.inst[i].o = state_reg.inst[i].sync_o[2];
      end

      // travel supervision
      want_cls = state_reg.inst[i].mode == ssup_pkg::SSUP_MOVE_CLOSE;
      sup = want_cls ? sup_cls : sup_opn;
      case (state_reg.inst[i].mode)
        ssup_pkg::SSUP_IDLE: begin
          // open wins over close; operable while withdrawn
          if (cmd_opn[i]) begin
            state_next.inst[i].mode = ssup_pkg::SSUP_MOVE_OPEN;
            state_next.inst[i].timer = state_reg.t_off[i];
            state_next.inst[i].fail = 1'b0;
          end else if (cmd_cls[i]) begin
            state_next.inst[i].mode = ssup_pkg::SSUP_MOVE_CLOSE;
            state_next.inst[i].timer = state_reg.t_on[i];
            state_next.inst[i].fail = 1'b0;
          end
        end
        ssup_pkg::SSUP_MOVE_CLOSE, ssup_pkg::SSUP_MOVE_OPEN: begin
          if (!wd && reached(state_reg.inst[i].c, state_reg.inst[i].o,
              won, woff, want_cls)) begin
            state_next.inst[i].mode = ssup_pkg::SSUP_IDLE;
            ev[2 * i + `SSUP_EV_OK] = sup;
          end else if (state_reg.inst[i].timer == 16'h0000 ||
              (tk && state_reg.inst[i].timer <= 16'h0001)) begin
            state_next.inst[i].mode = ssup_pkg::SSUP_IDLE;
            state_next.inst[i].fail = sup;
            ev[2 * i + `SSUP_EV_DIST] = sup;
          end else if (tk) begin
            state_next.inst[i].timer = state_reg.inst[i].timer -
              16'h0001;
          end
        end
        default: begin
          state_next.inst[i].mode = ssup_pkg::SSUP_IDLE;
        end
      endcase

      state_next.inst[i].cls_cmd =
        state_next.inst[i].mode == ssup_pkg::SSUP_MOVE_CLOSE;
      state_next.inst[i].opn_cmd =
        state_next.inst[i].mode == ssup_pkg::SSUP_MOVE_OPEN;

      // validated position
      want_cls = state_next.inst[i].mode == ssup_pkg::SSUP_MOVE_CLOSE;
      sup = want_cls ? sup_cls : sup_opn;
      if (wd) begin
        state_next.inst[i].pos = `SSUP_POS_OPEN;
      end else if (!won && !woff) begin
        state_next.inst[i].pos = `SSUP_POS_DIST;
      end else if (state_next.inst[i].mode != ssup_pkg::SSUP_IDLE &&
          sup) begin
        state_next.inst[i].pos = `SSUP_POS_INDET;
      end else if (state_next.inst[i].fail) begin
        state_next.inst[i].pos = `SSUP_POS_DIST;
      end else begin
        state_next.inst[i].pos = contact_pos(state_reg.inst[i].c,
          state_reg.inst[i].o, won, woff);
      end
    end

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        `SSUP_OFS_CTRL: state_next.ctrl = reg_wdata[4:0];
        `SSUP_OFS_EL_TON: state_next.t_on[0] = reg_wdata[15:0];
        `SSUP_OFS_EL_TOFF: state_next.t_off[0] = reg_wdata[15:0];
        `SSUP_OFS_TR_TON: state_next.t_on[1] = reg_wdata[15:0];
        `SSUP_OFS_TR_TOFF: state_next.t_off[1] = reg_wdata[15:0];
        `SSUP_OFS_IRQ_STAT: begin
          state_next.irq_stat = state_reg.irq_stat & ~reg_wdata[3:0];
        end
        `SSUP_OFS_IRQ_MASK: state_next.irq_mask = reg_wdata[3:0];
        default: begin
        end
      endcase
    end
    // new events win over a clear in the same cycle
    state_next.irq_stat = state_next.irq_stat | ev;
    state_next.irq = |(state_next.irq_stat & state_next.irq_mask);

    // register reads
    if (reg_rd) begin
      case (reg_addr)
        `SSUP_OFS_CTRL: state_next.rd_data = {27'h0, state_reg.ctrl};
        `SSUP_OFS_EL_TON: state_next.rd_data = {16'h0, state_reg.t_on[0]};
        `SSUP_OFS_EL_TOFF:
          state_next.rd_data = {16'h0, state_reg.t_off[0]};
        `SSUP_OFS_TR_TON: state_next.rd_data = {16'h0, state_reg.t_on[1]};
        `SSUP_OFS_TR_TOFF:
          state_next.rd_data = {16'h0, state_reg.t_off[1]};
        `SSUP_OFS_STATUS: begin
          state_next.rd_data = {26'h0, state_reg.rdy, state_reg.wd,
            state_reg.inst[1].pos, state_reg.inst[0].pos};
        end
        `SSUP_OFS_IRQ_STAT:
          state_next.rd_data = {28'h0, state_reg.irq_stat};
        `SSUP_OFS_IRQ_MASK:
          state_next.rd_data = {28'h0, state_reg.irq_mask};
        default: state_next.rd_data = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      state_reg <= '0;
      state_reg.t_on <= {2{`SSUP_TMOVE_RST}};
      state_reg.t_off <= {2{`SSUP_TMOVE_RST}};
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata = state_reg.rd_data;
  assign el_close_cmd = state_reg.inst[0].cls_cmd;
  assign el_open_cmd = state_reg.inst[0].opn_cmd;
  assign tr_close_cmd = state_reg.inst[1].cls_cmd;
  assign tr_open_cmd = state_reg.inst[1].opn_cmd;
  assign el_pos = state_reg.inst[0].pos;
  assign tr_pos = state_reg.inst[1].pos;
  assign el_withdrawn = state_reg.wd;
  assign irq = state_reg.irq;

endmodule

// ### rtl/ssup_defines.svh
// constants for the switchgear position supervisor
`ifndef SSUP_DEFINES_SVH
`define SSUP_DEFINES_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SSUP_CLK_NS 25
`define SSUP_TICK_NS 1000000
`define SSUP_TMOVE_RST 16'h00c8

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define SSUP_OFS_CTRL 8'h00
`define SSUP_OFS_CMD 8'h04
`define SSUP_OFS_EL_TON 8'h08
`define SSUP_OFS_EL_TOFF 8'h0c
`define SSUP_OFS_TR_TON 8'h10
`define SSUP_OFS_TR_TOFF 8'h14
`define SSUP_OFS_STATUS 8'h18
`define SSUP_OFS_IRQ_STAT 8'h1c
`define SSUP_OFS_IRQ_MASK 8'h20

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SSUP_CTRL_ROUTE 4
`define SSUP_ST_WD 4
`define SSUP_ST_RDY 5
`define SSUP_EV_OK 0
`define SSUP_EV_DIST 1

// ----------------------------------------------------------------
// position codes
// ----------------------------------------------------------------
`define SSUP_POS_INDET 2'h0
`define SSUP_POS_OPEN 2'h1
`define SSUP_POS_CLOSED 2'h2
`define SSUP_POS_DIST 2'h3

`endif

// ### rtl/ssup_pkg.sv
// types for the switchgear position supervisor
package ssup_pkg;

  typedef enum logic [1:0] {
    SSUP_IDLE,
    SSUP_MOVE_CLOSE,
    SSUP_MOVE_OPEN
  } ssup_mode_t;

  typedef struct packed {
    logic [2:0] sync_c;
    logic [2:0] sync_o;
    logic c;
    logic o;
    ssup_mode_t mode;
    logic [15:0] timer;
    logic fail;
    logic [1:0] pos;
    logic cls_cmd;
    logic opn_cmd;
  } ssup_inst_t;

  typedef struct packed {
    ssup_inst_t [1:0] inst;
    logic [2:0] sync_rdy;
    logic [2:0] sync_wd;
    logic rdy;
    logic wd;
    logic [15:0] tick;
    logic [4:0] ctrl;
    logic [1:0][15:0] t_on;
    logic [1:0][15:0] t_off;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [31:0] rd_data;
    logic irq;
  } ssup_state_t;

endpackage

// ### verif/ssup_sva.sv
// port assertions for the switchgear position supervisor
`timescale 1ns/1ps
`include "ssup_defines.svh"
module ssup_sva #(
  parameter int TICK_CYCLES = 4,
  parameter int MAX_T = 200
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic prot_open,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic el_withdrawn_in,
  input wire logic el_close_cmd,
  input wire logic el_open_cmd,
  input wire logic tr_close_cmd,
  input wire logic tr_open_cmd,
  input wire logic [1:0] el_pos,
  input wire logic el_withdrawn
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // close command length; limit assumes travel times up to MAX_T
  int unsigned run;
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b) run <= 0;
    else run <= el_close_cmd ? run + 1 : 0;
  sequence s_pin_held;
    el_withdrawn_in [*8];
  endsequence
  sequence s_cmd_write;
    clk_en && reg_wr && reg_addr == `SSUP_OFS_CMD;
  endsequence
  sequence s_el_idle;
    !el_close_cmd && !el_open_cmd;
  endsequence
  a_wd_forces_open: assert property (
    el_withdrawn && $past(el_withdrawn) |-> el_pos == `SSUP_POS_OPEN)
    else $error("element not open while withdrawn");
  a_wd_follows_pin: assert property (
    s_pin_held ##1 el_withdrawn_in |=> el_withdrawn)
    else $error("withdrawn state not taken");
  a_cmd_exclusive: assert property (
    !(el_close_cmd && el_open_cmd))
    else $error("close and open commands together");
  a_end_resolves: assert property (
    $fell(el_close_cmd) || $fell(el_open_cmd)
      |-> el_pos != `SSUP_POS_INDET)
    else $error("position still indeterminate after command");
  a_cmd_bounded: assert property (
    run <= MAX_T * TICK_CYCLES + 2)
    else $error("close command held too long");
  a_close_starts: assert property (
    s_cmd_write ##0 reg_wdata[1:0] == 2'h1 ##0 s_el_idle ##0 !prot_open
      |=> el_close_cmd)
    else $error("close command not started");
  a_open_wins: assert property (
    s_cmd_write ##0 reg_wdata[1:0] == 2'h3 ##0 s_el_idle
      |=> el_open_cmd && !el_close_cmd)
    else $error("open command did not win");
  a_truck_starts: assert property (
    s_cmd_write ##0 reg_wdata[3:2] == 2'h1 ##0 !tr_close_cmd && !tr_open_cmd
      |=> tr_close_cmd)
    else $error("truck close not started");
endmodule
bind ssup_top ssup_sva #(.TICK_CYCLES(TICK_CYCLES)) i_ssup_sva (
  .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
  .prot_open(prot_open), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .el_withdrawn_in(el_withdrawn_in),
  .el_close_cmd(el_close_cmd), .el_open_cmd(el_open_cmd),
  .tr_close_cmd(tr_close_cmd), .tr_open_cmd(tr_open_cmd),
  .el_pos(el_pos), .el_withdrawn(el_withdrawn));

// ### verif/ssup_gear.sv
// mechanism model with its auxiliary contacts
`timescale 1ns/1ps
module ssup_gear #(
  parameter int DLY = 6
) (
  input wire logic clk,
  input wire logic close_cmd,
  input wire logic open_cmd,
  input wire logic stuck,
  output logic closed_o,
  output logic open_o
);
  int cnt = 0;
  logic shut = 1'b0;
  // both contacts low while travelling; stuck never starts a travel
  // a started travel always finishes, like a released spring drive
  always @(posedge clk) begin
    if (cnt != 0 || !stuck && (close_cmd && !shut || open_cmd && shut)) begin
      cnt <= cnt + 1;
      if (cnt == DLY) begin
        shut <= !shut;
        cnt <= 0;
      end
    end
  end
  assign closed_o = shut && cnt == 0;
  assign open_o = !shut && cnt == 0;
endmodule

// ### verif/ssup_top_test.sv
// self-checking bench for the switchgear position supervisor
`timescale 1ns/1ps
`include "ssup_defines.svh"
module ssup_top_test;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, prot_close = 1'b0, prot_open = 1'b0;
  logic el_wd_in = 1'b0, el_stuck = 1'b0;
  logic el_c, el_o, tr_c, tr_o, el_cc, el_oc, tr_cc, tr_oc, el_wd, irq;
  logic [1:0] el_pos, tr_pos;
  logic [31:0] reg_rdata, d;
  int bad_count = 0, n_tests = 0, i;
  ssup_top #(.TICK_CYCLES(4)) i_ssup_top (
    .core_clk(core_clk), .rst_b(rst_b), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .el_closed_in(el_c), .el_open_in(el_o),
    .el_ready_in(1'b1), .el_withdrawn_in(el_wd_in), .tr_closed_in(tr_c),
    .tr_open_in(tr_o), .prot_close(prot_close), .prot_open(prot_open),
    .el_close_cmd(el_cc), .el_open_cmd(el_oc), .tr_close_cmd(tr_cc),
    .tr_open_cmd(tr_oc), .el_pos(el_pos), .tr_pos(tr_pos),
    .el_withdrawn(el_wd), .irq(irq));
  ssup_gear i_el_gear (.clk(core_clk), .close_cmd(el_cc), .open_cmd(el_oc),
    .stuck(el_stuck), .closed_o(el_c), .open_o(el_o));
  ssup_gear i_tr_gear (.clk(core_clk), .close_cmd(tr_cc), .open_cmd(tr_oc),
    .stuck(1'b0), .closed_o(tr_c), .open_o(tr_o));
  initial forever #12.5 core_clk = ~core_clk;
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", w, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic wait_idle(output int n);
    n = 0;
    while ((|{el_cc, el_oc, tr_cc, tr_oc}) === 1'b1 && n < 400) begin
      @(posedge core_clk);
      #1 n++;
    end
  endtask
  task automatic s_reset;
    rd(`SSUP_OFS_STATUS, d);
    chk("status", d, 32'h2f);
    rd(`SSUP_OFS_EL_TON, d);
    chk("el_ton", d, {16'h0, `SSUP_TMOVE_RST});
    rd(8'h24, d);
    chk("unmapped", d, 32'h0);
    $display("done reset");
  endtask
  task automatic s_close;
    wr(`SSUP_OFS_CTRL, 32'hf);
    wr(`SSUP_OFS_EL_TON, 32'h5);
    wr(`SSUP_OFS_IRQ_MASK, 32'h1);
    wr(`SSUP_OFS_CMD, 32'h1);
    chk("el_cc", el_cc, 1'b1);
    chk("el_pos", el_pos, `SSUP_POS_INDET);
    wait_idle(i);
    chk("el_pos", el_pos, `SSUP_POS_CLOSED);
    chk("early", i < 20, 1'b1);
    rd(`SSUP_OFS_IRQ_STAT, d);
    chk("stat", d, 32'h1);
    chk("irq", irq, 1'b1);
    wr(`SSUP_OFS_IRQ_STAT, 32'h1);
    rd(`SSUP_OFS_IRQ_STAT, d);
    chk("stat", d, 32'h0);
    chk("irq", irq, 1'b0);
    $display("done close");
  endtask
  task automatic s_open_fail;
    el_stuck <= 1'b1;
    wr(`SSUP_OFS_EL_TOFF, 32'h3);
    wr(`SSUP_OFS_CMD, 32'h3);
    chk("el_oc", el_oc, 1'b1);
    wait_idle(i);
    chk("length", i >= 8 && i <= 13, 1'b1);
    chk("el_pos", el_pos, `SSUP_POS_DIST);
    rd(`SSUP_OFS_IRQ_STAT, d);
    chk("stat", d, 32'h2);
    chk("irq", irq, 1'b0);
    wr(`SSUP_OFS_IRQ_STAT, 32'h2);
    el_stuck <= 1'b0;
    wr(`SSUP_OFS_EL_TOFF, 32'h5);
    wr(`SSUP_OFS_CMD, 32'h2);
    wait_idle(i);
    chk("el_pos", el_pos, `SSUP_POS_OPEN);
    $display("done open");
  endtask
  task automatic s_withdraw;
    @(posedge core_clk);
    el_wd_in <= 1'b1;
    repeat (10) @(posedge core_clk);
    #1 chk("el_wd", el_wd, 1'b1);
    chk("el_pos", el_pos, `SSUP_POS_OPEN);
    wr(`SSUP_OFS_CMD, 32'h1);
    chk("el_cc", el_cc, 1'b1);
    wait_idle(i);
    chk("length", i >= 16, 1'b1);
    chk("el_pos", el_pos, `SSUP_POS_OPEN);
    @(posedge core_clk);
    el_wd_in <= 1'b0;
    repeat (10) @(posedge core_clk);
    #1 chk("el_wd", el_wd, 1'b0);
    chk("el_pos", el_pos, `SSUP_POS_DIST);
    wr(`SSUP_OFS_CMD, 32'h1);
    wait_idle(i);
    chk("el_pos", el_pos, `SSUP_POS_CLOSED);
    rd(`SSUP_OFS_IRQ_STAT, d);
    chk("stat", d, 32'h3);
    wr(`SSUP_OFS_IRQ_STAT, 32'h3);
    $display("done withdraw");
  endtask
  task automatic s_truck;
    wr(`SSUP_OFS_TR_TON, 32'h4);
    wr(`SSUP_OFS_CMD, 32'h4);
    chk("tr_cc", tr_cc, 1'b1);
    chk("tr_pos", tr_pos, `SSUP_POS_INDET);
    wait_idle(i);
    chk("tr_pos", tr_pos, `SSUP_POS_CLOSED);
    chk("el_pos", el_pos, `SSUP_POS_CLOSED);
    rd(`SSUP_OFS_IRQ_STAT, d);
    chk("stat", d, 32'h4);
    wr(`SSUP_OFS_CMD, 32'h8);
    chk("tr_oc", tr_oc, 1'b1);
    wait_idle(i);
    chk("tr_pos", tr_pos, `SSUP_POS_OPEN);
    $display("done truck");
  endtask
  task automatic s_single;
    wr(`SSUP_OFS_CTRL, 32'hd);
    wr(`SSUP_OFS_CMD, 32'h2);
    chk("el_pos", el_pos, `SSUP_POS_CLOSED);
    wait_idle(i);
    chk("length", i >= 4 && i <= 8, 1'b1);
    chk("el_pos", el_pos, `SSUP_POS_OPEN);
    $display("done single");
  endtask
  task automatic s_prot;
    wr(`SSUP_OFS_CTRL, 32'h1f);
    @(posedge core_clk);
    prot_close <= 1'b1;
    @(posedge core_clk);
    prot_close <= 1'b0;
    #1 chk("el_cc", el_cc, 1'b1);
    wait_idle(i);
    chk("el_pos", el_pos, `SSUP_POS_CLOSED);
    @(posedge core_clk);
    prot_open <= 1'b1;
    @(posedge core_clk);
    prot_open <= 1'b0;
    #1 chk("el_oc", el_oc, 1'b1);
    wait_idle(i);
    chk("el_pos", el_pos, `SSUP_POS_OPEN);
    $display("done protection");
  endtask
  initial begin
    #100000;
    bad_count++;
    report_and_stop;
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
    s_reset;
    s_close;
    s_open_fail;
    s_withdraw;
    s_truck;
    s_single;
    s_prot;
    report_and_stop;
  end
endmodule
